// *** cis_pkg.sv ***
// constants and types shared by the interrupt sequencer
`default_nettype none
package cis_pkg;
  // sources: three external pins sit at indices 0..2
  localparam int NSRC = 8;
  localparam int NEXT = 3;
  localparam int PW   = 3;
  localparam int PCW  = 24;
  localparam int CNTW = 15;
  localparam int FRW  = 1 + 8 + PCW;  // priority msb, status low byte, pc
  // timed mask figures
  localparam logic [CNTW-1:0] CNT_MAX = 15'h4000;  // 16384 instruction cycles
  localparam logic [PW-1:0]   LVL_TOP = 3'h7;
  // register byte offsets
  localparam logic [7:0] A_FLAGS = 8'h00;
  localparam logic [7:0] A_ENAB  = 8'h04;
  localparam logic [7:0] A_PRIO  = 8'h08;
  localparam logic [7:0] A_CTL1  = 8'h0c;
  localparam logic [7:0] A_CTL2  = 8'h10;
  localparam logic [7:0] A_SR    = 8'h14;
  localparam logic [7:0] A_CORE  = 8'h18;
  localparam logic [7:0] A_CNT   = 8'h1c;
  localparam logic [7:0] A_VEC   = 8'h20;
  // field positions
  localparam int NEST_BIT = 15;
  localparam int TMS_BIT  = 14;
  localparam int MSB_BIT  = 3;
  localparam int IPL_LO   = 5;
  localparam int VEC_LO   = 8;
  localparam int VPR_LO   = 4;
  // reset values
  localparam logic [7:0]        SRL_RST = 8'h00;
  localparam logic [NSRC*PW-1:0] PRIO_RST = 24'h000000;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_EN1  = 4'h1,
    S_EN2  = 4'h2,
    S_EN3  = 4'h3,
    S_EN4  = 4'h4,
    S_RT1  = 4'h5,
    S_RT2  = 4'h6,
    S_RT3  = 4'h7,
    S_RT4  = 4'h8
  } cis_state_t;
endpackage
`default_nettype wire

// *** cis_sequencer.sv ***
// interrupt sequencer: request sampling, priority, entry/return, timed mask
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`default_nettype none
// Operation
// RULE1: timed mask hides levels 1-6 only
// RULE2: countdown decrements per cycle, mask while nonzero
// RULE3: software may clear or extend countdown
// RULE4: software write cannot start masking
// RULE5: control two bit 14 shows masking
// RULE6: sample flags and enables every cycle
// RULE7: running instruction always completes first
// RULE8: present only when priority exceeds cpu level
// RULE9: push pc, status low byte, priority msb
// RULE10: load request priority after stacking
// RULE11: return pops pc, msb, status byte
// RULE12: nesting default; nesting off forces level 7
// RULE13: nesting off: priority only breaks ties
// RULE14: cpu priority field read-only when nesting off
// RULE15: flagged enabled source wakes sleeping core
// RULE16: priority zero sources never wake
// RULE17: three pins with selectable edge polarity
// RULE18: pin zero edge also triggers converter
// RULE19: entry takes four cycles in fixed order
// RULE20: two-cycle instruction finishes in first entry cycles
// RULE21: return: two pops, fetch no-op, resume
// RULE22: stalled instruction adds one entry cycle
// RULE23: priority msb above field; msb set masks all
// RULE24: hardware sets flags, only software clears
module cis_sequencer
  import cis_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // request sources
  input  wire logic [NEXT-1:0]      ext_pins,
  input  wire logic [NSRC-NEXT-1:0] periph_req,
  output logic                      conv_trigger,
  // core side
  input  wire logic [PCW-1:0]    pc_in,
  input  wire logic              instr_stall,
  input  wire logic              timed_mask_op,
  input  wire logic [CNTW-1:0]   timed_mask_count,
  input  wire logic              return_op,
  input  wire logic [FRW-1:0]    pop_frame,
  output logic                   irq_present,
  output logic                   core_nop,
  output logic                   push_valid,
  output logic [FRW-1:0]         push_frame,
  output logic                   vector_load,
  output logic [PW-1:0]          vector_num,
  output logic                   handler_load,
  output logic                   pop_req,
  output logic [3:0]             cpu_level,
  output logic                   timed_mask_active,
  output logic                   wake,
  // axi4-lite slave
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [7:0]        araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp
);

  typedef struct packed {
    cis_state_t          st;
    logic [NSRC-1:0]     flags;
    logic [NSRC-1:0]     en;
    logic [NSRC*PW-1:0]  prio;
    logic                nest_off;
    logic [NEXT-1:0]     pol;
    logic [7:0]          status_low_byte;
    logic                msb;
    logic [CNTW-1:0]     cnt;
    logic [NEXT-1:0]     pin_q;
    logic                trig;
    logic [PW-1:0]       vec;
    logic [PW-1:0]       vprio;
    logic [FRW-1:0]      frame;
    logic                aw_ok;
    logic [7:0]          aw_a;
    logic                w_ok;
    logic [31:0]         w_d;
    logic [3:0]          w_s;
    logic                bv;
    logic [1:0]          br;
    logic                rv;
    logic [31:0]         rd;
    logic [1:0]          rr;
  } cis_reg_t;

  cis_reg_t st;
  cis_reg_t next_st;

  // register read decode, shared by the read path and byte-merge on writes
  function automatic logic [32:0] cis_rd(input cis_reg_t s, input logic [7:0] a);
    logic [31:0] r;
    logic        ok;
    r  = '0;
    ok = 1'b1;
    if (a == A_FLAGS) begin
      r[NSRC-1:0] = s.flags;
    end else if (a == A_ENAB) begin
      r[NSRC-1:0] = s.en;
    end else if (a == A_PRIO) begin
      r[NSRC*PW-1:0] = s.prio;
    end else if (a == A_CTL1) begin
      r[NEST_BIT] = s.nest_off;
    end else if (a == A_CTL2) begin
      r[TMS_BIT] = (s.cnt != '0);  // [RULE5]
      r[NEXT-1:0] = s.pol;
    end else if (a == A_SR) begin
      r[7:0] = s.status_low_byte;
    end else if (a == A_CORE) begin
      r[MSB_BIT] = s.msb;
    end else if (a == A_CNT) begin
      r[CNTW-1:0] = s.cnt;  // [RULE3]
    end else if (a == A_VEC) begin
      r[VEC_LO +: PW] = s.vec;
      r[VPR_LO +: PW] = s.vprio;
      r[3:0] = s.st;
    end else begin
      ok = 1'b0;
    end
    return {ok, r};
  endfunction

  // byte lanes selected by write strobes
  function automatic logic [31:0] cis_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // highest priority pending source; lower index wins ties, level 0 never counts
  function automatic logic [2*PW-1:0] cis_pick(input logic [NSRC-1:0] rq,
                                               input logic [NSRC*PW-1:0] pr);
    logic [PW-1:0] bi;
    logic [PW-1:0] bp;
    bi = '0;
    bp = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (rq[i] && pr[i*PW +: PW] > bp) begin  // [RULE13] [RULE16]
        bp = pr[i*PW +: PW];
        bi = PW'(i);
      end
    end
    return {bi, bp};
  endfunction

  logic [NEXT-1:0] ext_edge;
  logic [NSRC-1:0] nonzero;

  // edge detect against the previous sampled pin level
  genvar g;
  generate
    for (g = 0; g < NEXT; g++) begin : g_ext
      assign ext_edge[g] = st.pol[g] ? (st.pin_q[g] & ~ext_pins[g])
                                     : (~st.pin_q[g] & ext_pins[g]);  // [RULE17]
    end
    for (g = 0; g < NSRC; g++) begin : g_nz
      assign nonzero[g] = (st.prio[g*PW +: PW] != '0);
    end
  endgenerate

  logic [NSRC-1:0] pend;
  logic [PW-1:0]   best_i;
  logic [PW-1:0]   best_p;
  logic            req_ok;
  logic            tm_on;

  // flags gated by enables form requests each cycle
  assign pend = st.flags & st.en;  // [RULE6]
  assign {best_i, best_p} = cis_pick(pend, st.prio);
  assign tm_on = (st.cnt != '0);
  // msb set masks every user level; the timed mask spares level 7 only
  assign req_ok = (best_p != '0) && !st.msb && (best_p > st.status_low_byte[7:5])  // [RULE8] [RULE23]
                  && !(tm_on && best_p < LVL_TOP);  // [RULE1]

  assign irq_present = req_ok && (st.st == S_IDLE);
  assign wake = |(pend & nonzero);  // [RULE15] [RULE16]
  assign core_nop = (st.st == S_EN2) || (st.st == S_EN4) || (st.st == S_RT3);
  assign push_valid = (st.st == S_EN3);
  assign vector_load = (st.st == S_EN3);
  assign handler_load = (st.st == S_EN4);
  assign pop_req = (st.st == S_RT1) || (st.st == S_RT2);
  assign push_frame = st.frame;
  assign vector_num = st.vec;
  assign cpu_level = {st.msb, st.status_low_byte[7:5]};
  assign timed_mask_active = tm_on;
  assign conv_trigger = st.trig;
  // bus handshakes; the whole block, bus included, freezes while ce is low
  assign awready = ce && !st.aw_ok && !st.bv;
  assign wready = ce && !st.w_ok && !st.bv;
  assign arready = ce && !st.rv;
  assign bvalid = st.bv;
  assign bresp = st.br;
  assign rvalid = st.rv;
  assign rdata = st.rd;
  assign rresp = st.rr;

  logic [32:0] rd_w;
  logic [32:0] rd_r;
  logic [31:0] wm;
  logic [31:0] wv;
  logic        wr_go;

  // write merge: unstrobed lanes keep their old contents
  assign wr_go = st.aw_ok && st.w_ok && !st.bv;
  assign rd_w = cis_rd(st, st.aw_a);
  assign rd_r = cis_rd(st, araddr);
  assign wm = cis_mask(st.w_s);
  assign wv = (rd_w[31:0] & ~wm) | (st.w_d & wm);

  // next state of the whole block
  always_comb begin
    next_st = st;
    if (ce) begin
      // hardware set wins over a software clear in the same cycle
      next_st.flags = st.flags | {periph_req, ext_edge};  // [RULE24]
      next_st.pin_q = ext_pins;
      next_st.trig = ext_edge[0];  // [RULE18]
      if (st.cnt != '0) begin
        next_st.cnt = st.cnt - CNTW'(1);  // [RULE2]
      end
      // axi address and data taken in either order
      if (awvalid && awready) begin
        next_st.aw_ok = 1'b1;
        next_st.aw_a = awaddr;
      end
      if (wvalid && wready) begin
        next_st.w_ok = 1'b1;
        next_st.w_d = wdata;
        next_st.w_s = wstrb;
      end
      if (st.bv && bready) begin
        next_st.bv = 1'b0;
      end
      if (wr_go) begin
        next_st.aw_ok = 1'b0;
        next_st.w_ok = 1'b0;
        next_st.bv = 1'b1;
        next_st.br = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
        if (st.aw_a == A_FLAGS) begin
          next_st.flags = (st.flags & ~(st.w_d[NSRC-1:0] & wm[NSRC-1:0]))
                          | {periph_req, ext_edge};  // [RULE24]
        end else if (st.aw_a == A_ENAB) begin
          next_st.en = wv[NSRC-1:0];
        end else if (st.aw_a == A_PRIO) begin
          next_st.prio = wv[NSRC*PW-1:0];
        end else if (st.aw_a == A_CTL1) begin
          next_st.nest_off = wv[NEST_BIT];
        end else if (st.aw_a == A_CTL2) begin
          next_st.pol = wv[NEXT-1:0];
        end else if (st.aw_a == A_SR) begin
          next_st.status_low_byte[4:0] = wv[4:0];
          if (!st.nest_off) begin
            next_st.status_low_byte[7:5] = wv[7:5];  // [RULE14]
          end
        end else if (st.aw_a == A_CNT) begin
          // only an active count may be cleared or extended
          if (st.cnt != '0) begin
            next_st.cnt = wv[CNTW-1:0];  // [RULE3] [RULE4]
          end
        end
      end
      if (st.rv && rready) begin
        next_st.rv = 1'b0;
      end
      if (arvalid && arready) begin
        next_st.rv = 1'b1;
        next_st.rd = rd_r[31:0];
        next_st.rr = rd_r[32] ? RESP_OKAY : RESP_SLVERR;
      end
      // the instruction alone starts a masked period; it overrides software
      if (timed_mask_op) begin
        next_st.cnt = (timed_mask_count > CNT_MAX) ? CNT_MAX : timed_mask_count;  // [RULE1]
      end
      // entry and return sequencing
      case (st.st)
        S_IDLE: begin
          if (return_op) begin
            next_st.st = S_RT1;
          end else if (req_ok) begin
            next_st.st = S_EN1;
            next_st.vec = best_i;
            next_st.vprio = best_p;
          end
        end
        S_EN1: begin
          // current instruction completes here; each cycle of instr_stall holds S_EN1 one cycle more
          if (!instr_stall) begin
            next_st.st = S_EN2;  // [RULE7] [RULE20] [RULE22]
          end
        end
        S_EN2: begin
          next_st.frame = {st.msb, st.status_low_byte, pc_in};  // [RULE9] [RULE19]
          next_st.st = S_EN3;
        end
        S_EN3: begin
          // stacking done; raise level, or to 7 when nesting is off
          next_st.status_low_byte[7:5] = st.nest_off ? LVL_TOP : st.vprio;  // [RULE10] [RULE12]
          next_st.st = S_EN4;  // [RULE19]
        end
        S_EN4: begin
          next_st.st = S_IDLE;  // [RULE19]
        end
        S_RT1: begin
          next_st.st = S_RT2;  // [RULE21]
        end
        S_RT2: begin
          next_st.msb = pop_frame[FRW-1];  // [RULE11]
          next_st.status_low_byte = pop_frame[FRW-2 -: 8];
          next_st.st = S_RT3;
        end
        S_RT3: begin
          next_st.st = S_RT4;  // [RULE21]
        end
        S_RT4: begin
          next_st.st = S_IDLE;
        end
        default: begin
          next_st.st = S_IDLE;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.st <= S_IDLE;
      st.status_low_byte <= SRL_RST;
      st.prio <= PRIO_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ent;
    st.st == S_EN2 && ce ##1 st.st == S_EN3 && ce;
  endsequence
  sequence s_ret;
    st.st == S_RT1 && ce ##1 st.st == S_RT2 && ce;
  endsequence

  a_mask_low_levels: assert property (tm_on && best_p < LVL_TOP |-> !irq_present) // [RULE1]
    else $error("timed mask let a low level through");
  a_count_decrements: assert property (ce && tm_on && !timed_mask_op && !wr_go
    |=> st.cnt == $past(st.cnt) - CNTW'(1)) // [RULE2]
    else $error("countdown did not decrement");
  a_sw_no_start: assert property (ce && !tm_on && !timed_mask_op |=> !tm_on) // [RULE4]
    else $error("masking started without the instruction");
  a_present_level: assert property (irq_present |-> !st.msb && best_p > cpu_level[2:0]) // [RULE8]
    else $error("request presented at or below cpu level");
  a_entry_level: assert property (st.st == S_EN3 && ce && !st.nest_off
    |=> cpu_level == {1'b0, $past(st.vprio)}) // [RULE10]
    else $error("entry did not load request priority");
  a_nest_force: assert property (st.st == S_EN3 && ce && st.nest_off
    |=> cpu_level[2:0] == LVL_TOP) // [RULE12]
    else $error("nesting off did not force level 7");
  a_entry_steps: assert property (s_ent |=> st.st == S_EN4 && handler_load) // [RULE19]
    else $error("entry sequence out of order");
  a_return_steps: assert property (s_ret |=> st.st == S_RT3 && core_nop) // [RULE21]
    else $error("return sequence out of order");
  a_zero_no_wake: assert property ((pend & nonzero) == '0 |-> !wake) // [RULE16]
    else $error("wake without an enabled nonzero source");

endmodule
`default_nettype wire

// *** cis_core_model.sv ***
// core model: program counter source and software stack
`default_nettype none
module cis_core_model
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // sequencer side
  input  wire logic           push_valid,
  input  wire logic [FRW-1:0] push_frame,
  input  wire logic           pop_req,
  output logic      [PCW-1:0] pc_in,
  output logic      [FRW-1:0] pop_frame
);
  logic [FRW-1:0] stk [4];
  logic [2:0]     sp;
  logic           pop_q;
  // pc moves every cycle so a late capture shows up as a wrong frame
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_in <= 24'h000100;
      sp    <= 3'h0;
      pop_q <= 1'b0;
    end else begin
      pc_in <= pc_in + 24'h000002;
      pop_q <= pop_req;
      if (push_valid) begin
        stk[sp[1:0]] <= push_frame;
        sp           <= sp + 3'h1;
      end else if (pop_q && !pop_req) begin
        sp <= sp - 3'h1;
      end
    end
  end
  // an empty stack gives a moving pattern, never a stale frame
  assign pop_frame = (sp != 3'h0) ? stk[sp[1:0] - 2'h1] : ~{pc_in[8:0], pc_in};
endmodule
`default_nettype wire

// *** cis_sequencer_tb.sv ***
// random and directed bench for the interrupt sequencer
`default_nettype none
`define CHK(nm, e, a) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, a); \
  end \
end
module cis_sequencer_tb
  import cis_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk, rst, ce, instr_stall, timed_mask_op, return_op;
  logic                 conv_trigger, irq_present, core_nop, push_valid, vector_load;
  logic                 handler_load, pop_req, timed_mask_active, wake;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [NEXT-1:0]      ext_pins, w;
  logic [NSRC-NEXT-1:0] periph_req;
  logic [PCW-1:0]       pc_in, pcs;
  logic [FRW-1:0]       pop_frame, push_frame;
  logic [CNTW-1:0]      timed_mask_count;
  logic [PW-1:0]        vector_num, p;
  logic [3:0]           cpu_level, wstrb;
  logic [7:0]           awaddr, araddr, s;
  logic [31:0]          wdata, rdata, rd_v;
  logic [31:0]          seed = 32'hb53e;
  logic [1:0]           bresp, rresp, lr;
  int                   n_mismatch, n_compared, n_trig, n, t, c, pin, pol;

  cis_sequencer u_dut (
    .clk, .rst, .ce, .ext_pins, .periph_req, .conv_trigger, .pc_in, .instr_stall,
    .timed_mask_op, .timed_mask_count, .return_op, .pop_frame, .irq_present, .core_nop,
    .push_valid, .push_frame, .vector_load, .vector_num, .handler_load, .pop_req,
    .cpu_level, .timed_mask_active, .wake, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp
  );
  cis_core_model u_core (.clk, .rst, .push_valid, .push_frame, .pop_req, .pc_in, .pop_frame);

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // converter trigger is a one-cycle pulse, so count edges that see it
  always @(posedge clk) begin
    if (conv_trigger === 1'b1) n_trig++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // bus master: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    lr = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    lr = rresp;
  endtask
  task automatic pulse(input logic [4:0] m);
    periph_req <= m;
    @(posedge clk);
    periph_req <= 5'h00;
  endtask
  // walks the entry states; st stall cycles stretch the first one
  task automatic entry(input int st, input logic [2:0] v, input logic [8:0] hi,
                       input logic [3:0] lvl);
    for (t = 0; irq_present !== 1'b1 && t < 50; t++) @(posedge clk);
    `CHK("present", 1'b1, irq_present)
    instr_stall <= (st != 0);
    #1;
    `CHK("en1 nop", 1'b0, core_nop)
    if (st != 0) begin
      repeat (st) @(posedge clk);
      instr_stall <= 1'b0;
    end
    @(posedge clk);
    #1;
    `CHK("en2 nop", 1'b1, core_nop)
    pcs = pc_in;
    @(posedge clk);
    #1;
    `CHK("en3", 2'b11, {push_valid, vector_load})
    `CHK("frame", {hi, pcs}, push_frame)
    `CHK("vector", v, vector_num)
    @(posedge clk);
    #1;
    `CHK("en4", 2'b11, {handler_load, core_nop})
    `CHK("level", lvl, cpu_level)
    @(posedge clk);
  endtask
  task automatic ret(input logic [3:0] lvl);
    return_op <= 1'b1;
    @(posedge clk);
    return_op <= 1'b0;
    repeat (2) begin
      #1;
      `CHK("pop", 1'b1, pop_req)
      @(posedge clk);
    end
    #1;
    `CHK("rt3", 2'b01, {pop_req, core_nop})
    repeat (2) @(posedge clk);
    #1;
    `CHK("restore", lvl, cpu_level)
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    {rst, ce, wstrb} = 6'h3f;
    {ext_pins, periph_req, instr_stall, timed_mask_op, return_op} = '0;
    {timed_mask_count, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // plain and stalled entries with random level and status byte
    wr(A_ENAB, 32'hf8);
    for (int i = 0; i < 4; i++) begin
      p = 3'(rnd() % 6) + 3'h1;
      s = {3'h0, 5'(rnd())};
      wr(A_PRIO, {20'h0, p, 9'h0});
      wr(A_SR, {24'h0, s});
      pulse(5'h01);
      entry(i, 3'h3, {1'b0, s}, {1'b0, p});
      rd(A_FLAGS, rd_v);
      `CHK("flag held", 1'b1, rd_v[3])
      wr(A_FLAGS, 32'h08);
      ret(4'h0);
    end
    $display("entry test done");
    // nesting: equal level waits, higher level preempts
    wr(A_PRIO, 32'h0002b600);
    wr(A_SR, 32'h0);
    pulse(5'h01);
    entry(0, 3'h3, 9'h000, 4'h3);
    pulse(5'h02);
    repeat (3) @(posedge clk);
    `CHK("equal held", 1'b0, irq_present)
    pulse(5'h04);
    entry(0, 3'h5, 9'h060, 4'h5);
    wr(A_FLAGS, 32'h20);
    ret(4'h3);
    wr(A_FLAGS, 32'h18);
    ret(4'h0);
    // nesting off: tie won by priority, level forced, field locked
    wr(A_CTL1, 32'h8000);
    pulse(5'h05);
    entry(0, 3'h5, 9'h000, 4'h7);
    // look once the sequencer is back in idle, not while entry still blocks it
    @(posedge clk);
    `CHK("no nest", 1'b0, irq_present)
    wr(A_SR, 32'h0);
    rd(A_SR, rd_v);
    `CHK("field ro", 3'h7, rd_v[7:5])
    wr(A_FLAGS, 32'h28);
    ret(4'h0);
    wr(A_CTL1, 32'h0);
    $display("nesting test done");
    // wake needs a nonzero level but ignores the cpu level
    wr(A_PRIO, 32'h0);
    pulse(5'h08);
    @(posedge clk);
    `CHK("wake lvl0", 1'b0, wake)
    // raise the cpu level first, or the level-1 source would start an entry
    wr(A_SR, 32'he0);
    wr(A_PRIO, 32'h00040000);
    `CHK("wake", 2'b10, {wake, irq_present})
    wr(A_FLAGS, 32'h40);
    wr(A_SR, 32'h0);
    $display("wake test done");
    // timed mask
    wr(A_CNT, 32'h10);
    rd(A_CNT, rd_v);
    `CHK("soft start", 16'h0, {timed_mask_active, rd_v[14:0]})
    n = int'(rnd() % 16) + 4;
    timed_mask_count <= 15'(n);
    timed_mask_op <= 1'b1;
    @(posedge clk);
    timed_mask_op <= 1'b0;
    #1;
    for (t = 0; timed_mask_active === 1'b1 && t < 100; t++) @(posedge clk) #1;
    `CHK("mask length", n, t)
    @(posedge clk);
    wr(A_PRIO, 32'h00038c00);
    timed_mask_count <= 15'h7fff;
    timed_mask_op <= 1'b1;
    @(posedge clk);
    timed_mask_op <= 1'b0;
    pulse(5'h01);
    rd(A_CTL2, rd_v);
    `CHK("mask bit", 1'b1, rd_v[TMS_BIT])
    rd(A_CNT, rd_v);
    `CHK("cap", 1'b1, rd_v[14:0] <= CNT_MAX && rd_v[14:0] > 15'h3ff0)
    `CHK("low masked", 1'b0, irq_present)
    wr(A_CNT, 32'h100);
    rd(A_CNT, rd_v);
    `CHK("rewrite", 1'b1, rd_v[14:0] <= 15'h100 && rd_v[14:0] > 15'hf0)
    pulse(5'h04);
    entry(0, 3'h5, 9'h000, 4'h7);
    wr(A_FLAGS, 32'h20);
    ret(4'h0);
    `CHK("still masked", 1'b0, irq_present)
    wr(A_CNT, 32'h0);
    entry(0, 3'h3, 9'h000, 4'h6);
    wr(A_FLAGS, 32'h08);
    ret(4'h0);
    $display("timed mask test done");
    // each pin and polarity: wrong edge first, then the right one
    for (int k = 0; k < 6; k++) begin
      pin = k % 3;
      pol = k / 3;
      w = 3'h1 << pin;
      wr(A_CTL2, 32'(pol) << pin);
      ext_pins <= (pol != 0) ? 3'h0 : w;
      repeat (3) @(posedge clk);
      wr(A_FLAGS, 32'h07);
      c = n_trig;
      ext_pins <= (pol != 0) ? w : 3'h0;
      repeat (3) @(posedge clk);
      rd(A_FLAGS, rd_v);
      `CHK("wrong edge", 3'h0, rd_v[2:0])
      ext_pins <= (pol != 0) ? 3'h0 : w;
      repeat (3) @(posedge clk);
      rd(A_FLAGS, rd_v);
      `CHK("right edge", w, rd_v[2:0])
      `CHK("disabled", 1'b0, irq_present)
      `CHK("trigger", (pin == 0) ? 1 : 0, n_trig - c)
    end
    $display("pin test done");
    wr(8'h3c, 32'h1);
    `CHK("unmapped wr", RESP_SLVERR, lr)
    rd(8'h3c, rd_v);
    `CHK("unmapped rd", RESP_SLVERR, lr)
    $display("bus test done");
    end_sim();
  end
endmodule
`default_nettype wire
